//--- rtl/wwd_top.sv
// Window watchdog and microcontroller reset generator with AHB-Lite registers.
// Assumes pins are asynchronous; the bus runs on sys_clk; one AHB slave.
// Summary of operation
// (RL1) Hold reset low during rail undervoltage or power-on, then 10 ms more.
// (RL2) Heartbeat rising and falling edges both count as transitions.
// (RL3) Microcontroller holds heartbeat steady at least the minimum time.
// (RL4) Timer restarts only on transitions between minimum and minimum plus window.
// (RL5) Early or missing transition sets fault flag and pulls reset low 10 ms.
// (RL6) After reset release, timer held 100 ms and heartbeat ignored.
// (RL7) No first transition within minimum plus window repeats the reset cycle.
// (RL8) First transition after a micro reset skips the minimum time check.
// (RL9) Fault flag stays set until software clears it.
// (RL10) Failure disables gate drive until a valid transition re-enables it.
// (RL11) Mask bit set disables all watchdog monitoring and actions.
// (RL12) Limit N allows N fail-reset cycles; next failure enters sleep.
// (RL13) A valid transition clears the fail-cycle counter.
// (RL14) Valid means after the hold-off and inside the first window.
// (RL15) Limit zero disables sleep-on-failure, unlimited cycles.
// (RL16) Program mode disables watchdog and floats the reset output.
// (RL17) Sleep holds reset low, clears faults and status to zero.
// (RL18) Times are tick counts; 10 ms and 100 ms are fixed counts.
// (RL19) Heartbeat is synchronised before edge detection, one event per change.
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`default_nettype none
module wwd_top import wwd_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device pins
  input wire logic heartbeat_in,
  input wire logic logic_rail_uv,
  input wire logic program_mode_pin,
  input wire logic wake_pin,
  output logic micro_reset_n_o,
  output logic micro_reset_n_oe,
  output logic gate_enable,
  output logic sleep_state,
  output logic irq
);
  // Byte offset match on a word-aligned address
  function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
    hit = (a[31:8] == 24'h00_0000) && (a[7:0] == ofs);
  endfunction : hit

  // Synchronised pins
  logic [3:0] pins_s;
  logic hb_s;
  logic uv_s;
  logic pm_s;
  logic wake_s;
  wwd_sync #(.WIDTH(4)) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in({wake_pin, program_mode_pin, logic_rail_uv, heartbeat_in}),
    .sync_out(pins_s)
  ); // see (RL19)
  assign hb_s = pins_s[0];
  assign uv_s = pins_s[1];
  assign pm_s = pins_s[2];
  assign wake_s = pins_s[3];

  // Timebase
  logic tick;
  logic restart;
  wwd_tick #(.TICK_CYCLES(TICK_CYCLES_P)) u_tick (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clr(restart),
    .tick(tick)
  );

  // Bus state
  logic wr_pend_reg, wr_pend_next;
  logic rd_pend_reg, rd_pend_next;
  logic [31:0] addr_reg, addr_next;
  logic hready_reg, hready_next;
  logic [31:0] hrdata_reg, hrdata_next;
  // Software state
  logic [7:0] min_reg, min_next;
  logic [7:0] win_reg, win_next;
  logic [3:0] lim_reg, lim_next;
  logic mask_reg, mask_next;
  logic [IRQ_W-1:0] irq_en_reg, irq_en_next;
  // Supervisor state
  wwd_state_t st_reg, st_next;
  logic [15:0] tcnt_reg, tcnt_next;
  logic [3:0] fail_reg, fail_next;
  logic flag_reg, flag_next;
  logic gate_reg, gate_next;
  logic hb_prev_reg;
  logic [IRQ_W-1:0] irq_st_reg, irq_st_next;
  logic mrst_reg, mrst_next;
  logic oe_reg, irq_reg, irq_next;

  logic addr_ok;
  logic wr_data;
  logic flag_clr;
  logic [IRQ_W-1:0] irq_clr;
  logic hb_edge;
  logic dis;
  logic fault;
  logic valid;
  logic release_ev;
  logic [15:0] minwin;

  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_data = wr_pend_reg;
  assign flag_clr = wr_data && hit(addr_reg, OFS_FLAG_CLR) && hwdata[ST_FLAG_BIT];
  assign irq_clr = (wr_data && hit(addr_reg, OFS_IRQ_CLR)) ? hwdata[IRQ_W-1:0] : '0;
  assign hb_edge = hb_s ^ hb_prev_reg; // see (RL2) (RL19)
  assign dis = mask_reg || pm_s; // see (RL11) (RL16)
  assign minwin = 16'(min_reg) + 16'(win_reg);

  // Bus phases: writes take no wait, reads one wait state
  always_comb begin
    wr_pend_next = addr_ok && hwrite;
    rd_pend_next = addr_ok && !hwrite;
    addr_next = addr_ok ? haddr : addr_reg;
    hready_next = !(addr_ok && !hwrite);
    hrdata_next = hrdata_reg;
    if (rd_pend_reg) begin
      hrdata_next = 32'h0000_0000;
      if (hit(addr_reg, OFS_CTRL)) begin
        hrdata_next[CTRL_MIN_LSB +: 8] = min_reg;
        hrdata_next[CTRL_WIN_LSB +: 8] = win_reg;
        hrdata_next[CTRL_LIM_LSB +: 4] = lim_reg;
        hrdata_next[CTRL_MASK_BIT] = mask_reg;
      end else if (hit(addr_reg, OFS_STATUS)) begin
        hrdata_next[ST_FLAG_BIT] = flag_reg;
        hrdata_next[ST_GATE_BIT] = gate_reg;
        hrdata_next[ST_SLEEP_BIT] = (st_reg == ST_SLEEP);
        hrdata_next[ST_MRST_BIT] = mrst_reg;
        hrdata_next[ST_FAIL_LSB +: 4] = fail_reg;
      end else if (hit(addr_reg, OFS_IRQ_STAT)) begin
        hrdata_next[IRQ_W-1:0] = irq_st_reg;
      end else if (hit(addr_reg, OFS_IRQ_EN)) begin
        hrdata_next[IRQ_W-1:0] = irq_en_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
      hready_reg <= hready_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Configuration registers, written in the data phase
  always_comb begin
    min_next = min_reg;
    win_next = win_reg;
    lim_next = lim_reg;
    mask_next = mask_reg;
    irq_en_next = irq_en_reg;
    if (wr_data && hit(addr_reg, OFS_CTRL)) begin
      min_next = hwdata[CTRL_MIN_LSB +: 8]; // see (RL18)
      win_next = hwdata[CTRL_WIN_LSB +: 8];
      lim_next = hwdata[CTRL_LIM_LSB +: 4];
      mask_next = hwdata[CTRL_MASK_BIT];
    end else if (wr_data && hit(addr_reg, OFS_IRQ_EN)) begin
      irq_en_next = hwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      min_reg <= MIN_RST;
      win_reg <= WIN_RST;
      lim_reg <= LIM_RST;
      mask_reg <= MASK_RST;
      irq_en_reg <= '0;
    end else begin
      min_reg <= min_next;
      win_reg <= win_next;
      lim_reg <= lim_next;
      mask_reg <= mask_next;
      irq_en_reg <= irq_en_next;
    end
  end

  // Supervisor: reset pulse, hold-off, first window, running window, sleep
  always_comb begin
    st_next = st_reg;
    tcnt_next = tick ? tcnt_reg + 16'h0001 : tcnt_reg; // see (RL18)
    restart = 1'b0;
    fault = 1'b0;
    valid = 1'b0;
    release_ev = 1'b0;
    gate_next = gate_reg;
    fail_next = fail_reg;
    case (st_reg)
      ST_RESET: begin
        gate_next = 1'b0;
        if (uv_s) begin
          restart = 1'b1; // see (RL1)
        end else if (tcnt_reg >= RST_LOW_TICKS) begin
          st_next = dis ? ST_RUN : ST_HOLD; // see (RL1) (RL5)
          gate_next = dis;
          restart = 1'b1;
          release_ev = 1'b1;
        end
      end
      ST_HOLD: begin
        // Heartbeat ignored here
        if (dis) begin
          st_next = ST_RUN;
          restart = 1'b1;
        end else if (tcnt_reg >= HOLD_TICKS) begin
          st_next = ST_FIRST; // see (RL6)
          restart = 1'b1;
        end
      end
      ST_FIRST: begin
        if (dis) begin
          st_next = ST_RUN;
          restart = 1'b1;
        end else if (hb_edge) begin
          valid = 1'b1; // see (RL8) (RL14)
        end else if (tcnt_reg >= minwin) begin
          fault = 1'b1; // see (RL7)
        end
      end
      ST_RUN: begin
        if (dis) begin
          restart = 1'b1; // see (RL11) (RL16)
          gate_next = 1'b1;
        end else if (hb_edge) begin
          if (tcnt_reg < 16'(min_reg)) begin
            fault = 1'b1; // see (RL5) (RL3)
          end else begin
            valid = 1'b1; // see (RL4)
          end
        end else if (tcnt_reg >= minwin) begin
          fault = 1'b1; // see (RL5)
        end
      end
      ST_SLEEP: begin
        gate_next = 1'b0;
        fail_next = 4'h0; // see (RL17)
        if (wake_s) begin
          st_next = ST_RESET;
          restart = 1'b1;
        end
      end
      default: begin
        st_next = ST_RESET;
        restart = 1'b1;
      end
    endcase
    if (valid) begin
      st_next = ST_RUN;
      restart = 1'b1; // see (RL4)
      fail_next = 4'h0; // see (RL13)
      gate_next = 1'b1; // see (RL10)
    end
    if (fault) begin
      restart = 1'b1;
      gate_next = 1'b0; // see (RL10)
      if (lim_reg != 4'h0 && fail_reg >= lim_reg) begin
        st_next = ST_SLEEP; // see (RL12) (RL15)
      end else begin
        st_next = ST_RESET; // see (RL5)
        fail_next = (fail_reg == 4'hF) ? fail_reg : fail_reg + 4'h1;
      end
    end
    // Undervoltage overrides everything but sleep
    if (uv_s && st_reg != ST_SLEEP && st_reg != ST_RESET) begin
      st_next = ST_RESET; // see (RL1)
      restart = 1'b1;
      gate_next = 1'b0;
    end
    if (restart) begin
      tcnt_next = 16'h0000;
    end
    mrst_next = !(st_next == ST_RESET || st_next == ST_SLEEP); // see (RL17)
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= ST_RESET;
      tcnt_reg <= 16'h0000;
      fail_reg <= 4'h0;
      gate_reg <= 1'b0;
      hb_prev_reg <= 1'b0;
      mrst_reg <= 1'b0;
      oe_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      tcnt_reg <= tcnt_next;
      fail_reg <= fail_next;
      gate_reg <= gate_next;
      hb_prev_reg <= hb_s;
      mrst_reg <= mrst_next;
      oe_reg <= !pm_s; // see (RL16)
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_comb begin
    flag_next = flag_reg;
    if (flag_clr) begin
      flag_next = 1'b0;
    end
    if (fault) begin
      flag_next = 1'b1; // see (RL5) (RL9)
    end
    irq_st_next = irq_st_reg & ~irq_clr;
    irq_st_next[IRQ_FAULT] = irq_st_next[IRQ_FAULT] | fault;
    irq_st_next[IRQ_RELEASE] = irq_st_next[IRQ_RELEASE] | release_ev;
    irq_st_next[IRQ_VALID] = irq_st_next[IRQ_VALID] | valid;
    // Sleep wipes status, so nothing stays pending across it
    if (st_reg == ST_SLEEP) begin
      flag_next = 1'b0; // see (RL17)
      irq_st_next = '0;
    end
    irq_next = |(irq_st_next & irq_en_reg);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
      irq_st_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      irq_st_reg <= irq_st_next;
      irq_reg <= irq_next;
    end
  end

  // Outputs from flops, except hresp, tied to OKAY, and sleep_state, decoded from the state register
  assign hreadyout = hready_reg;
  assign hresp = 1'b0; // Always OKAY
  assign hrdata = hrdata_reg;
  assign micro_reset_n_o = mrst_reg;
  assign micro_reset_n_oe = oe_reg;
  assign gate_enable = gate_reg;
  assign sleep_state = (st_reg == ST_SLEEP);
  assign irq = irq_reg;

  // Size field unused: every access is treated as a full word
  logic unused_ok;
  assign unused_ok = ^hsize;
endmodule : wwd_top
`default_nettype wire

//--- rtl/wwd_pkg.sv
// Package for the window watchdog and micro reset block.
// Assumes a 250 MHz system clock; timing counts derive from it.
`default_nettype none
package wwd_pkg;
  // Clock and timebase
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_TIME_NS = 1_000_000; // 1 ms timebase tick
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  // Fixed intervals, in ms and in ticks
  localparam int RST_LOW_TIME_MS = 10;
  localparam int HOLD_TIME_MS = 100;
  localparam logic [15:0] RST_LOW_TICKS = 16'(RST_LOW_TIME_MS * 1_000_000 / TICK_TIME_NS);
  localparam logic [15:0] HOLD_TICKS = 16'(HOLD_TIME_MS * 1_000_000 / TICK_TIME_NS);
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FLAG_CLR = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  // Control field positions
  localparam int CTRL_MIN_LSB = 0;
  localparam int CTRL_WIN_LSB = 8;
  localparam int CTRL_LIM_LSB = 16;
  localparam int CTRL_MASK_BIT = 20;
  // Status field positions
  localparam int ST_FLAG_BIT = 0;
  localparam int ST_GATE_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  localparam int ST_MRST_BIT = 3;
  localparam int ST_FAIL_LSB = 4;
  // Values after reset
  localparam logic [7:0] MIN_RST = 8'h0A;
  localparam logic [7:0] WIN_RST = 8'h14;
  localparam logic [3:0] LIM_RST = 4'h0;
  localparam logic MASK_RST = 1'b0;
  // Interrupt event bits
  localparam int IRQ_W = 3;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_RELEASE = 1;
  localparam int IRQ_VALID = 2;
  // Supervisor states
  typedef enum logic [2:0] {
    ST_RESET,
    ST_HOLD,
    ST_FIRST,
    ST_RUN,
    ST_SLEEP
  } wwd_state_t;
endpackage : wwd_pkg
`default_nettype wire

//--- rtl/wwd_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes inputs are quasi-static levels; no bus coherency across bits.
`default_nettype none
module wwd_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Pins and synchronised levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : wwd_sync
`default_nettype wire

//--- rtl/wwd_tick.sv
// Timebase prescaler: one-cycle tick every TICK_CYCLES clocks.
// Assumes the caller clears it to align the tick with an interval start.
`default_nettype none
module wwd_tick #(
  parameter int TICK_CYCLES = 250_000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control and tick
  input wire logic clr,
  output logic tick
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // Wrap count; clear restarts a full period
  always_comb begin
    cnt_next = cnt_reg + 32'h0000_0001;
    tick_next = 1'b0;
    if (clr) begin
      cnt_next = 32'h0000_0000;
    end else if (cnt_reg >= 32'(TICK_CYCLES - 1)) begin
      cnt_next = 32'h0000_0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule : wwd_tick
`default_nettype wire

//--- bench/wwd_top_asserts.sv
// Checker for the watchdog top: bus answer, reset pulse length and supervisor timing.
// Assumes hready is the slave's own hreadyout and that the pins change at clock edges.
`default_nettype none
module wwd_top_chk import wwd_pkg::*; #(
  parameter int TICK_CYCLES_P = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic logic_rail_uv,
  input wire logic program_mode_pin,
  input wire logic micro_reset_n_o,
  input wire logic micro_reset_n_oe,
  input wire logic gate_enable,
  input wire logic sleep_state
);
  localparam int LO = int'(RST_LOW_TICKS) * TICK_CYCLES_P - 2;
  localparam int HI = LO + 16;
  localparam int BOUND = (int'(HOLD_TICKS) + int'(MIN_RST) + int'(WIN_RST)) * TICK_CYCLES_P + 25;
  int lo_cnt, lo_next, hi_cnt, hi_next;
  // Low run since its cause went, and wait for a first heartbeat; slack covers pin sync
  always_comb begin
    lo_next = (micro_reset_n_o || logic_rail_uv || sleep_state) ? 0 : lo_cnt + 1;
    hi_next = (!micro_reset_n_o || gate_enable) ? 0 : hi_cnt + 1;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lo_cnt <= 0;
      hi_cnt <= 0;
    end else begin
      lo_cnt <= lo_next;
      hi_cnt <= hi_next;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence rd_take;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  // Bus answers
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (rd_take |=> rd_wait)
    else $error("read wait state wrong");
  // Reset output
  a_uv_reset: assert property (logic_rail_uv [*4] ##0 !program_mode_pin |-> !micro_reset_n_o)
    else $error("reset not low under undervoltage");
  a_low_len: assert property ($rose(micro_reset_n_o) |-> lo_cnt inside {[LO:HI]})
    else $error("reset low time wrong");
  a_fault_gate: assert property ($fell(micro_reset_n_o) |-> ##1 !gate_enable)
    else $error("gate drive left on at reset");
  a_first_bound: assert property (micro_reset_n_o && !gate_enable |-> hi_cnt < BOUND)
    else $error("no reset after missed first window");
  a_prog_float: assert property (program_mode_pin [*5] |-> !micro_reset_n_oe)
    else $error("reset pin driven in program mode");
  a_sleep_hold: assert property (sleep_state [*2] |-> !micro_reset_n_o)
    else $error("reset released in sleep");
endmodule : wwd_top_chk
bind wwd_top wwd_top_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .logic_rail_uv(logic_rail_uv), .program_mode_pin(program_mode_pin),
  .micro_reset_n_o(micro_reset_n_o), .micro_reset_n_oe(micro_reset_n_oe), .gate_enable(gate_enable),
  .sleep_state(sleep_state));
`default_nettype wire

//--- bench/wwd_mcu_model.sv
// Behavioural microcontroller: toggles the heartbeat pin and obeys its reset pin.
// Assumes the bench resolves the reset pin with its pull-up.
`default_nettype none
module wwd_mcu_model (
  // Clock and reset pin
  input wire logic sys_clk,
  input wire logic rst_pin,
  // Heartbeat timing in clocks; first of zero keeps the pin still
  input wire logic [15:0] first,
  input wire logic [15:0] period,
  // Heartbeat pin
  output var logic heartbeat
);
  int cnt;
  logic started;
  initial begin
    heartbeat = 1'b0;
    cnt = 0;
    started = 1'b0;
  end
  // Pin floats while held in reset, so it wanders every cycle
  always @(posedge sys_clk) begin
    if (!rst_pin) begin
      heartbeat <= ~heartbeat;
      cnt <= 0;
      started <= 1'b0;
    end else if (first != 0) begin
      cnt <= cnt + 1;
      if (cnt + 1 >= int'(started ? period : first)) begin
        heartbeat <= ~heartbeat;
        cnt <= 0;
        started <= 1'b1;
      end
    end
  end
endmodule : wwd_mcu_model
`default_nettype wire

//--- bench/wwd_top_tb.sv
// Self-checking bench for the watchdog top: bus tasks, heartbeat partner, fault cases.
// Assumes one AHB slave whose hreadyout is the bus hready.
`default_nettype none
module wwd_top_tb import wwd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 10;
  logic sys_clk, resetn, hsel, hwrite, hb, uv, prog, wake, was;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rd;
  logic [15:0] first, period;
  wire logic hready, hresp, rst_o, rst_oe, gate, sleep, irq;
  wire logic [31:0] hrdata;
  wire logic rst_pin = rst_oe ? rst_o : 1'b1;
  int miscompares, comparisons, cyc, n, falls;
  wwd_top #(.TICK_CYCLES_P(TC)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .heartbeat_in(hb), .logic_rail_uv(uv), .program_mode_pin(prog),
    .wake_pin(wake), .micro_reset_n_o(rst_o), .micro_reset_n_oe(rst_oe), .gate_enable(gate),
    .sleep_state(sleep), .irq(irq));
  wwd_mcu_model u_mcu (.sys_clk(sys_clk), .rst_pin(rst_pin), .first(first), .period(period), .heartbeat(hb));
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One single transfer; bounded waits so a dead slave cannot hang the run
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin @(posedge sys_clk); k++; end while (hready !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge sys_clk); k++; end while (hready !== 1'b1 && k < 50);
    rd = hrdata;
  endtask : bus
  function automatic logic [31:0] ctrl_w(input int mn, input int wn, input int lim, input logic msk);
    return (32'(mn) << CTRL_MIN_LSB) | (32'(wn) << CTRL_WIN_LSB) | (32'(lim) << CTRL_LIM_LSB) |
      (32'(msk) << CTRL_MASK_BIT);
  endfunction : ctrl_w
  task automatic wait_on(input int s, input logic v, input int max);
    n = 0;
    while ((s == 0 ? gate : s == 1 ? rst_o : sleep) !== v && n < max) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_on
  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    {hsel, hwrite, uv, prog, wake, resetn} = 6'h00;
    {htrans, haddr, hwdata} = '0;
    first = 16'h0406;
    period = 16'h00C8;
    {miscompares, comparisons, cyc} = '0;
    void'($urandom(29));
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    period <= 16'($urandom_range(280, 120));
    bus(1'h0, 32'(OFS_CTRL), 0);
    check("ctrl reset", rd, ctrl_w(MIN_RST, WIN_RST, LIM_RST, MASK_RST));
    bus(1'h0, 32'h0000_0040, 0);
    check("unmapped", rd, 32'h0000_0000);
    bus(1'h1, 32'(OFS_IRQ_EN), 32'h0000_0001);
    wait_on(0, 1'h1, 3000);
    check("gate first", gate, 1'h1);
    repeat (1500) @(posedge sys_clk);
    bus(1'h0, 32'(OFS_STATUS), 0);
    check("status run", rd[7:0], 8'h0A);
    // Early edge: fault, flag, interrupt raised, masked, cleared
    period <= 16'h0032;
    wait_on(1, 1'h0, 1000);
    bus(1'h0, 32'(OFS_STATUS), 0);
    check("status fault", rd[7:0], 8'h11);
    check("irq fault", irq, 1'h1);
    bus(1'h1, 32'(OFS_IRQ_EN), 0);
    repeat (3) @(posedge sys_clk);
    check("irq masked", irq, 1'h0);
    bus(1'h1, 32'(OFS_IRQ_EN), 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    check("irq unmasked", irq, 1'h1);
    bus(1'h1, 32'(OFS_IRQ_CLR), 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    check("irq cleared", irq, 1'h0);
    bus(1'h0, 32'(OFS_STATUS), 0);
    check("flag kept", rd[0], 1'h1);
    bus(1'h1, 32'(OFS_FLAG_CLR), 32'h0000_0001);
    bus(1'h0, 32'(OFS_STATUS), 0);
    check("flag cleared", rd[0], 1'h0);
    period <= 16'($urandom_range(280, 120));
    wait_on(1, 1'h1, 200);
    wait_on(0, 1'h1, 3000);
    check("hold off", n >= 1000, 1'h1);
    check("gate back", gate, 1'h1);
    // Silent with limit zero, then recovery clears the fail count
    first <= 16'h0000;
    repeat (6000) @(posedge sys_clk);
    check("no sleep", sleep, 1'h0);
    bus(1'h0, 32'(OFS_STATUS), 0);
    check("fails counted", rd[7:4] != 4'h0, 1'h1);
    first <= 16'h0406;
    wait_on(0, 1'h1, 4000);
    bus(1'h0, 32'(OFS_STATUS), 0);
    check("fails cleared", rd[7:4], 4'h0);
    // Limit two: two fail cycles allowed, third failure sleeps
    bus(1'h1, 32'(OFS_CTRL), ctrl_w(10, 20, 2, 1'h0));
    first <= 16'h0000;
    falls = 0;
    was = rst_o;
    repeat (5000) begin
      @(posedge sys_clk);
      falls += int'(was && !rst_o);
      was = rst_o;
    end
    check("fail cycles", falls, 3);
    check("asleep", sleep, 1'h1);
    bus(1'h0, 32'(OFS_STATUS), 0);
    check("sleep status", rd, 32'h0000_0001 << ST_SLEEP_BIT);
    first <= 16'h0406;
    wake <= 1'h1;
    wait_on(2, 1'h0, 100);
    wake <= 1'h0;
    check("awake", sleep, 1'h0);
    wait_on(0, 1'h1, 4000);
    check("gate after wake", gate, 1'h1);
    // Undervoltage restarts the reset pulse
    uv <= 1'h1;
    repeat (30) @(posedge sys_clk);
    check("uv reset", rst_o, 1'h0);
    uv <= 1'h0;
    wait_on(1, 1'h1, 300);
    check("uv tail", n inside {[100:120]}, 1'h1);
    // Mask: silence causes nothing
    bus(1'h1, 32'(OFS_CTRL), ctrl_w(10, 20, 0, 1'h1));
    bus(1'h0, 32'(OFS_CTRL), 0);
    check("ctrl rw", rd, ctrl_w(10, 20, 0, 1'h1));
    first <= 16'h0000;
    repeat (3000) @(posedge sys_clk);
    check("masked reset", rst_o, 1'h1);
    check("masked gate", gate, 1'h1);
    bus(1'h0, 32'(OFS_STATUS), 0);
    check("masked flag", rd[0], 1'h0);
    // Program mode floats the reset pin
    prog <= 1'h1;
    repeat (6) @(posedge sys_clk);
    check("prog float", rst_oe, 1'h0);
    prog <= 1'h0;
    repeat (6) @(posedge sys_clk);
    check("prog drive", rst_oe, 1'h1);
    complete_run();
  end
endmodule : wwd_top_tb
`default_nettype wire
